// *** common/prf_pkg.sv ***
`default_nettype none
package prf_pkg;
    // pixel array geometry and word layout
    localparam int unsigned NUM_PIXELS    = 16;
    localparam int unsigned WORD_W        = 30;
    localparam int unsigned RAM_DEPTH     = 256;
    localparam int unsigned RAM_AW        = 8;
    localparam int unsigned PATCNT_W      = 16;
    localparam int unsigned TAG_W         = 4;
    localparam int unsigned BX_W          = 12;
    localparam logic [9:0]  PAT_MSB_CONST = 10'h2AA;   // 10'b1010101010
    localparam logic [17:0] SOF_CONST     = 18'h25555;
    localparam logic [29:0] EOF_WORD      = 30'h2EADBEFF;
    localparam logic [29:0] IDLE_WORD     = 30'h00000000;

    // word clock derived from the system clock, longest period rounds down
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned WORD_MHZ      = 40;
    localparam int unsigned WORD_DIV      = CLK_MHZ / WORD_MHZ;
    localparam logic [2:0]  WORD_DIV_LAST = 3'(WORD_DIV - 1);

    // register byte offsets
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_MASK      = 5'h04;
    localparam logic [4:0]  REG_TAG_LO    = 5'h08;
    localparam logic [4:0]  REG_TAG_HI    = 5'h0C;
    localparam logic [4:0]  REG_STATUS    = 5'h10;

    // control register fields
    localparam int unsigned CTRL_TEST_BIT  = 0;
    localparam int unsigned CTRL_FRAME_BIT = 1;
    localparam int unsigned CTRL_COL_LSB   = 8;
    localparam int unsigned CTRL_ROW_LSB   = 12;
    // status register fields
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_TRIG_LSB  = 4;
    localparam int unsigned STAT_BX_LSB    = 16;

    // reset values
    localparam logic [31:0] CTRL_RESET    = 32'h00000000;
    localparam logic [15:0] MASK_RESET    = 16'hFFFF;
    localparam logic [63:0] TAG_RESET     = 64'hFEDCBA9876543210;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b00,
        ST_BODY    = 2'b01,
        ST_TRAILER = 2'b10
    } prf_state_t;
endpackage
`default_nettype wire

// *** design/prf_pixel_readout_framer.sv ***
// How it works
// - test control picks pattern, else TDC word
// - low 16 pattern bits from word counter
// - pattern bits 19:16 are pixel tag
// - pattern bits 29:20 fixed 1010101010
// - test control drives TDC monitor enable
// - tag bits shared with DAC; DAC bypassed in test
// - diag mode streams one pixel continuously
// - diag pixel chosen by column and row
// - each pixel owns 256x30 capture RAM
// - four column buses feed one controller
// - capture writes all RAMs, address advances
// - accept stops writes, sends header first
// - each enabled pixel dumps whole RAM once
// - trailer after last pixel, resume capture
// - mask bit enables same-index pixel
// - fixed order 15,11,7,3,14 ... 4,0
// - header constant plus id, trailer constant
// - 12-bit bunch count, cleared by zero marker
// - accept captures bunch count as identifier
// - active scheme selects serializer stream
// - one 30-bit word per word clock
//
// The address map and the Avalon-MM slave port were left to the implementer.
`default_nettype none
module prf_pixel_readout_framer
    import prf_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            nrst,
    input  wire logic [4:0]                      avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [31:0]                     avs_writedata,
    input  wire logic [3:0]                      avs_byteenable,
    output logic      [31:0]                     avs_readdata,
    output logic                                 avs_waitrequest,
    input  wire logic [NUM_PIXELS*WORD_W-1:0]    tdcData,
    input  wire logic                            level1Accept,
    input  wire logic                            bunchZeroMarker,
    output logic      [WORD_W-1:0]               serialWord,
    output logic                                 serialWordValid,
    output logic                                 tdcMonitorEnable,
    output logic                                 dacBypass,
    output logic      [NUM_PIXELS*TAG_W-1:0]     dacTrimLow,
    output logic                                 frameBusy
);

    // ---------------- register slave ----------------
    logic [31:0] ctrlQ, ctrlD;
    logic [15:0] maskQ, maskD;
    logic [63:0] tagQ, tagD;
    logic [31:0] rdataQ, rdataD;
    logic        waitQ, waitD;
    logic [31:0] byteMask;
    logic [31:0] statusWord;

    prf_state_t           stateQ, stateD;
    logic [BX_W-1:0]      bxQ, bxD;
    logic [BX_W-1:0]      trigIdQ, trigIdD;

    // status shows the block's own state
    assign statusWord = (32'(frameBusy) << STAT_BUSY_BIT) | (32'(trigIdQ) << STAT_TRIG_LSB)
                      | (32'(bxQ) << STAT_BX_LSB);

    // one wait cycle per access: decode, then complete on the next edge
    always_comb begin
        ctrlD    = ctrlQ;
        maskD    = maskQ;
        tagD     = tagQ;
        rdataD   = rdataQ;
        waitD    = 1'b1;
        byteMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        if ((avs_read || avs_write) && waitQ) begin
            waitD = 1'b0;
            unique case ({avs_address[4:2], 2'b00})
                REG_CTRL:   rdataD = ctrlQ;
                REG_MASK:   rdataD = {16'h0000, maskQ};
                REG_TAG_LO: rdataD = tagQ[31:0];
                REG_TAG_HI: rdataD = tagQ[63:32];
                REG_STATUS: rdataD = statusWord;
                default:    rdataD = 32'h00000000;   // unmapped reads as zero
            endcase
        end else if (avs_write && !waitQ) begin
            unique case ({avs_address[4:2], 2'b00})
                REG_CTRL:   ctrlD = (ctrlQ & ~byteMask) | (avs_writedata & byteMask);
                REG_MASK:   maskD = (maskQ & ~byteMask[15:0]) | (avs_writedata[15:0] & byteMask[15:0]);
                REG_TAG_LO: tagD[31:0] = (tagQ[31:0] & ~byteMask) | (avs_writedata & byteMask);
                REG_TAG_HI: tagD[63:32] = (tagQ[63:32] & ~byteMask) | (avs_writedata & byteMask);
                default:    ;                        // status and unmapped ignore writes
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlQ  <= CTRL_RESET;
            maskQ  <= MASK_RESET;
            tagQ   <= TAG_RESET;
            rdataQ <= 32'h00000000;
            waitQ  <= 1'b1;
        end else begin
            ctrlQ  <= ctrlD;
            maskQ  <= maskD;
            tagQ   <= tagD;
            rdataQ <= rdataD;
            waitQ  <= waitD;
        end
    end

    assign avs_readdata    = rdataQ;
    assign avs_waitrequest = waitQ;

    logic       testSel;
    logic       frameMode;
    logic [3:0] diagCol;
    logic [3:0] diagRow;
    assign testSel   = ctrlQ[CTRL_TEST_BIT];
    assign frameMode = ctrlQ[CTRL_FRAME_BIT];
    assign diagCol   = ctrlQ[CTRL_COL_LSB +: 4];
    assign diagRow   = ctrlQ[CTRL_ROW_LSB +: 4];

    // ---------------- word clock enable and event inputs ----------------
    logic [2:0] divQ, divD;
    logic       wordEn;
    logic [2:0] l1SyncQ, bzSyncQ;
    logic       l1Pulse, bzPulse;
    logic       l1PendQ, l1PendD, bzPendQ, bzPendD;

    // edges are taken between the second and third stages only
    assign l1Pulse = l1SyncQ[1] && !l1SyncQ[2];
    assign bzPulse = bzSyncQ[1] && !bzSyncQ[2];
    assign wordEn  = (divQ == WORD_DIV_LAST);

    // pending latches hold a pulse until the next word slot; set beats clear
    always_comb begin
        divD    = wordEn ? 3'h0 : divQ + 3'h1;
        bzPendD = (bzPendQ && !wordEn) || bzPulse;
        l1PendD = (l1PendQ && !(wordEn && stateQ == ST_CAPTURE))
                || (l1Pulse && stateQ == ST_CAPTURE && frameMode);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divQ    <= 3'h0;
            l1SyncQ <= 3'h0;
            bzSyncQ <= 3'h0;
            l1PendQ <= 1'b0;
            bzPendQ <= 1'b0;
        end else begin
            divQ    <= divD;
            l1SyncQ <= {l1SyncQ[1:0], level1Accept};
            bzSyncQ <= {bzSyncQ[1:0], bunchZeroMarker};
            l1PendQ <= l1PendD;
            bzPendQ <= bzPendD;
        end
    end

    // ---------------- pattern generation and per-pixel mux ----------------
    logic [PATCNT_W-1:0] patCntQ, patCntD;
    logic [WORD_W-1:0]   pixWord [NUM_PIXELS];

    // counter steps once per word clock
    always_comb begin
        patCntD = wordEn ? patCntQ + 16'h0001 : patCntQ;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            patCntQ <= 16'h0000;
        end else begin
            patCntQ <= patCntD;
        end
    end

    // each pixel's word: pattern or TDC, the sixteen pixels differ by tag
    for (genvar p = 0; p < NUM_PIXELS; p++) begin : g_pix
        assign pixWord[p] = testSel ? {PAT_MSB_CONST, tagQ[p*TAG_W +: TAG_W], patCntQ}
                                    : tdcData[p*WORD_W +: WORD_W];
    end

    // ---------------- capture RAMs ----------------
    // one 256x30 store per pixel
    logic [WORD_W-1:0] pixRam [NUM_PIXELS][RAM_DEPTH];
    logic [RAM_AW-1:0] wrAddrQ, wrAddrD;
    logic              writeEn;

    assign writeEn = (stateQ == ST_CAPTURE);

    // address wraps modulo 256 by width
    always_comb begin
        wrAddrD = (wordEn && writeEn) ? wrAddrQ + 8'h01 : wrAddrQ;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrAddrQ <= 8'h00;
        end else begin
            wrAddrQ <= wrAddrD;
        end
    end

    // memory has no reset; contents are undefined until written once
    always_ff @(posedge clk) begin
        if (wordEn && writeEn) begin
            for (int p = 0; p < NUM_PIXELS; p++) begin
                pixRam[p][wrAddrQ] <= pixWord[p];
            end
        end
    end

    // ---------------- frame controller ----------------
    logic [4:0]        ordQ, ordD;      // position in readout order
    logic [RAM_AW-1:0] rdAddrQ, rdAddrD;
    logic [RAM_AW-1:0] rdCntQ, rdCntD;
    logic [WORD_W-1:0] frameWord;
    logic [3:0]        curPix;
    logic [WORD_W-1:0] colBus [4];
    logic              nxtFound;
    logic [4:0]        nxtOrd;

    function automatic logic [3:0] ordToPix(input logic [4:0] o);
        ordToPix = 4'hF - {2'b00, o[3:2]} - {o[1:0], 2'b00};
    endfunction

    // first enabled pixel at or after a position
    function automatic logic [5:0] findNext(input logic [15:0] m, input logic [4:0] from);
        logic [5:0] r;
        r = 6'h00;
        for (int i = NUM_PIXELS - 1; i >= 0; i--) begin
            if (5'(i) >= from && m[ordToPix(5'(i))]) begin
                r = {1'b1, 5'(i)};
            end
        end
        findNext = r;
    endfunction

    assign curPix = ordToPix(ordQ);

    // column bus carries the addressed row of that column
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            colBus[c] = pixRam[{curPix[3:2], 2'(c)}][rdAddrQ];
        end
    end

    always_comb begin
        stateD    = stateQ;
        ordD      = ordQ;
        rdAddrD   = rdAddrQ;
        rdCntD    = rdCntQ;
        trigIdD   = trigIdQ;
        frameWord = IDLE_WORD;
        nxtFound  = 1'b0;
        nxtOrd    = 5'h00;
        // bunch count runs every word, zero marker clears
        bxD       = wordEn ? (bzPendQ ? 12'h000 : bxQ + 12'h001) : bxQ;
        if (wordEn) begin
            unique case (stateQ)
                ST_CAPTURE: begin
                    if (l1PendQ && frameMode) begin
                        frameWord = {SOF_CONST, bxQ};
                        trigIdD   = bxQ;
                        {nxtFound, nxtOrd} = findNext(maskQ, 5'h00);
                        ordD      = nxtOrd;
                        rdAddrD   = wrAddrQ + 8'h01;   // this slot still writes wrAddrQ, next entry is oldest
                        rdCntD    = 8'h00;
                        stateD    = nxtFound ? ST_BODY : ST_TRAILER;
                    end
                end
                ST_BODY: begin
                    // one full RAM loop per pixel
                    frameWord = colBus[curPix[1:0]];
                    rdAddrD   = rdAddrQ + 8'h01;
                    rdCntD    = rdCntQ + 8'h01;
                    if (rdCntQ == 8'hFF) begin
                        {nxtFound, nxtOrd} = findNext(maskQ, ordQ + 5'h01);
                        ordD   = nxtOrd;
                        stateD = nxtFound ? ST_BODY : ST_TRAILER;
                    end
                end
                ST_TRAILER: begin
                    frameWord = EOF_WORD;
                    stateD    = ST_CAPTURE;
                end
                default: stateD = ST_CAPTURE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateQ  <= ST_CAPTURE;
            ordQ    <= 5'h00;
            rdAddrQ <= 8'h00;
            rdCntQ  <= 8'h00;
            trigIdQ <= 12'h000;
            bxQ     <= 12'h000;
        end else begin
            stateQ  <= stateD;
            ordQ    <= ordD;
            rdAddrQ <= rdAddrD;
            rdCntQ  <= rdCntD;
            trigIdQ <= trigIdD;
            bxQ     <= bxD;
        end
    end

    // ---------------- output stream ----------------
    logic [WORD_W-1:0]           outWordQ, outWordD;
    logic                        outValidQ, outValidD;
    logic                        monQ, busyQ;
    logic [NUM_PIXELS*TAG_W-1:0] trimQ;
    logic [WORD_W-1:0]           diagWord;

    // pixel index is row times four plus column
    assign diagWord = pixWord[{diagRow[1:0], diagCol[1:0]}];

    // frame words win over diag while a frame is open, so a mode change never tears a frame
    always_comb begin
        outWordD  = outWordQ;
        outValidD = wordEn;
        if (wordEn) begin
            if (frameMode || stateQ != ST_CAPTURE) begin
                outWordD = frameWord;
            end else begin
                outWordD = diagWord;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outWordQ  <= IDLE_WORD;
            outValidQ <= 1'b0;
            monQ      <= 1'b0;
            busyQ     <= 1'b0;
            trimQ     <= TAG_RESET;
        end else begin
            outWordQ  <= outWordD;
            outValidQ <= outValidD;
            // monitor on and DAC bypassed in test
            monQ      <= testSel;
            busyQ     <= (stateD != ST_CAPTURE);
            trimQ     <= tagQ;
        end
    end

    assign serialWord       = outWordQ;
    assign serialWordValid  = outValidQ;
    assign tdcMonitorEnable = monQ;
    assign dacBypass        = monQ;
    assign dacTrimLow       = trimQ;
    assign frameBusy        = busyQ;

    // ---------------- assertions ----------------
    sequence acceptTaken;
        wordEn && stateQ == ST_CAPTURE && l1PendQ && frameMode;
    endsequence
    sequence bodyLast;
        wordEn && stateQ == ST_BODY && rdCntQ == 8'hFF;
    endsequence

    header_word_a: assert property (@(posedge clk) disable iff (!nrst)
        acceptTaken |=> serialWord == {SOF_CONST, $past(bxQ)} && serialWordValid)
        else $error("header word wrong after accept");
    trailer_return_a: assert property (@(posedge clk) disable iff (!nrst)
        wordEn && stateQ == ST_TRAILER |=> serialWord == EOF_WORD ##0 stateQ == ST_CAPTURE)
        else $error("trailer or return to capture missing");
    write_blocked_a: assert property (@(posedge clk) disable iff (!nrst)
        acceptTaken |=> !writeEn ##1 (!writeEn && $stable(wrAddrQ)))
        else $error("writes not blocked during frame");
    pixel_step_a: assert property (@(posedge clk) disable iff (!nrst)
        bodyLast |=> rdAddrQ == $past(wrAddrQ) && rdCntQ == 8'h00)
        else $error("pixel dump not one full loop");
    pattern_word_a: assert property (@(posedge clk) disable iff (!nrst)
        testSel |-> pixWord[5][29:20] == PAT_MSB_CONST && pixWord[5][19:16] == tagQ[23:20])
        else $error("pattern fixed bits or tag wrong");
    monitor_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(testSel) |=> tdcMonitorEnable && dacBypass)
        else $error("monitor enable not following test select");
    bunch_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        wordEn && bzPendQ |=> bxQ == 12'h000)
        else $error("bunch count not cleared");
    word_rate_a: assert property (@(posedge clk) disable iff (!nrst)
        serialWordValid |=> !serialWordValid [*5] ##1 serialWordValid)
        else $error("word rate not one per word clock");
    accept_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        stateQ != ST_CAPTURE |=> !l1PendQ || $past(l1PendQ))
        else $error("accept latched during frame");
    bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

endmodule // prf_pixel_readout_framer
`default_nettype wire

// *** verif/prf_far_side.sv ***
`default_nettype none
module prf_far_side
    import prf_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic [25:0]                  tdcBase,
    input  wire logic [WORD_W-1:0]            serialWord,
    input  wire logic                         serialWordValid,
    output logic      [NUM_PIXELS*WORD_W-1:0] tdcData,
    output logic                              gapBad
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap;

    // every tdc reports its own index under a shared base, so a body word names its pixel
    always_comb begin
        for (int p = 0; p < NUM_PIXELS; p++) begin
            tdcData[p*WORD_W +: WORD_W] = {tdcBase, 4'(p)};
        end
    end

    // fixed word cadence
    // the serializer cannot stall the block, so any gap other than one word period is a fault
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap <= 0;
            gapBad <= 1'b0;
        end else if (serialWordValid) begin
            if (gap != 0 && gap != WORD_DIV) gapBad <= 1'b1;
            gap <= 1;
        end else if (gap != 0) begin
            gap <= gap + 1;
        end
    end
endmodule // prf_far_side
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench;
    import prf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic                         clk = 1'b0;
    logic                         nrst = 1'b0;
    logic [4:0]                   avs_address = 5'h00;
    logic                         avs_read = 1'b0;
    logic                         avs_write = 1'b0;
    logic [31:0]                  avs_writedata = 32'h00000000;
    logic [31:0]                  avs_readdata;
    logic                         avs_waitrequest;
    logic [NUM_PIXELS*WORD_W-1:0] tdcData;
    logic                         level1Accept = 1'b0;
    logic                         bunchZeroMarker = 1'b0;
    logic [WORD_W-1:0]            serialWord;
    logic                         serialWordValid;
    logic                         tdcMonitorEnable;
    logic                         dacBypass;
    logic [NUM_PIXELS*TAG_W-1:0]  dacTrimLow;
    logic                         frameBusy;
    logic [25:0]                  tdcBase = 26'h0123456;
    logic                         gapBad;
    int                           err_total = 0;
    int                           total_checks = 0;

    always #2 clk = ~clk;

    prf_pixel_readout_framer u_prf_pixel_readout_framer (
        .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tdcData(tdcData), .level1Accept(level1Accept),
        .bunchZeroMarker(bunchZeroMarker), .serialWord(serialWord), .serialWordValid(serialWordValid),
        .tdcMonitorEnable(tdcMonitorEnable), .dacBypass(dacBypass), .dacTrimLow(dacTrimLow),
        .frameBusy(frameBusy)
    );
    prf_far_side u_prf_far_side (
        .clk(clk), .nrst(nrst), .tdcBase(tdcBase), .serialWord(serialWord),
        .serialWordValid(serialWordValid), .tdcData(tdcData), .gapBad(gapBad)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic hang(input string m);
        err_total++;
        $display("mismatch at %0t: %s wait ran out", $time, m);
        tally_and_finish();
    endtask

    // one access: request held until waitrequest is seen low, then one idle edge before the next
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 32);
        if (n >= 32) hang("bus");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic next_word(output logic [29:0] w);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (serialWordValid !== 1'b1 && n < 16);
        if (n >= 16) hang("word");
        w = serialWord;
    endtask

    task automatic slots(input int k);
        logic [29:0] w;
        repeat (k) next_word(w);
    endtask

    task automatic test_reset_regs();
        logic [31:0] q;
        chk(frameBusy === 1'b0 && tdcMonitorEnable === 1'b0 && dacBypass === 1'b0, "reset outputs");
        chk(dacTrimLow === TAG_RESET, "reset tags on dac lines");
        bus(1'b0, REG_CTRL, 32'h0, q);
        chk(q === CTRL_RESET, "ctrl reset");
        bus(1'b0, REG_MASK, 32'h0, q);
        chk(q[15:0] === MASK_RESET, "mask reset");
        bus(1'b0, REG_TAG_LO, 32'h0, q);
        chk(q === TAG_RESET[31:0], "tag lo reset");
        bus(1'b0, REG_TAG_HI, 32'h0, q);
        chk(q === TAG_RESET[63:32], "tag hi reset");
        bus(1'b1, 5'h14, 32'hFFFFFFFF, q);
        bus(1'b0, 5'h14, 32'h0, q);
        chk(q === 32'h00000000, "unmapped read");
        $display("test reset_regs done");
    endtask

    task automatic test_diag_tdc();
        logic [29:0] w;
        logic [3:0]  r;
        logic [3:0]  c;
        logic [31:0] q;
        for (int i = 0; i < 3; i++) begin
            r = 4'(i * 3 % 4);
            c = 4'(3 - i);
            bus(1'b1, REG_CTRL, {16'h0, r, c, 8'h00}, q);
            slots(2);
            next_word(w);
            chk(w === {tdcBase, r[1:0], c[1:0]}, "diag tdc word");
            chk(tdcMonitorEnable === 1'b0 && dacBypass === 1'b0, "monitor off");
        end
        $display("test diag_tdc done");
    endtask

    task automatic test_diag_pattern();
        logic [29:0] w1;
        logic [29:0] w2;
        logic [31:0] q;
        bus(1'b1, REG_TAG_LO, 32'h5A5A5A5A, q);
        // tag lines are registered one edge after the tag register itself
        @(posedge clk);
        chk(dacTrimLow[31:0] === 32'h5A5A5A5A, "tags shared with dac");
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, REG_CTRL, {20'h0, 4'(c), 8'h01}, q);
            slots(2);
            chk(tdcMonitorEnable === 1'b1 && dacBypass === 1'b1, "monitor and bypass on");
            next_word(w1);
            next_word(w2);
            chk(w1[29:20] === PAT_MSB_CONST, "pattern top bits");
            chk(w1[19:16] === ((c == 0) ? 4'hA : 4'h5), "pattern tag");
            chk(w2[15:0] === w1[15:0] + 16'h1, "pattern counter step");
        end
        $display("test diag_pattern done");
    endtask

    // zero marker and accept are driven with the same shape, so their pipeline delays cancel
    task automatic run_empty(input int k, output logic [11:0] id);
        logic [29:0] w;
        int          n;
        bunchZeroMarker <= 1'b1;
        repeat (4) @(posedge clk);
        bunchZeroMarker <= 1'b0;
        repeat (WORD_DIV * k - 4) @(posedge clk);
        level1Accept <= 1'b1;
        repeat (4) @(posedge clk);
        level1Accept <= 1'b0;
        n = 0;
        do begin
            next_word(w);
            n++;
        end while (w === IDLE_WORD && n < 10);
        chk(w[29:12] === SOF_CONST, "header constant");
        id = w[11:0];
        next_word(w);
        chk(w === EOF_WORD, "trailer after empty body");
        slots(2);
        chk(frameBusy === 1'b0, "back to capture");
    endtask

    task automatic test_frame_ids();
        logic [29:0] w;
        logic [31:0] q;
        logic [11:0] id1;
        logic [11:0] id2;
        bus(1'b1, REG_CTRL, 32'h00000002, q);
        bus(1'b1, REG_MASK, 32'h00000000, q);
        slots(2);
        next_word(w);
        chk(w === IDLE_WORD, "frame mode idle word");
        run_empty(10, id1);
        run_empty(50, id2);
        chk(id2 - id1 === 12'h028, "trigger id follows bunch count");
        chk(id1 < 12'h00E, "bunch count cleared by zero marker");
        bus(1'b0, REG_STATUS, 32'h0, q);
        chk(q[STAT_TRIG_LSB +: BX_W] === id2 && q[STAT_BUSY_BIT] === 1'b0, "status id and idle");
        $display("test frame_ids done");
    endtask

    task automatic test_frame_body();
        int          ord [16] = '{15, 11, 7, 3, 14, 10, 6, 2, 13, 9, 5, 1, 12, 8, 4, 0};
        logic [15:0] mask = 16'h9A01;
        logic [25:0] oldBase;
        logic [29:0] w;
        logic [31:0] q;
        int          n;
        logic        first;
        bus(1'b1, REG_MASK, {16'h0, mask}, q);
        tdcBase <= 26'h2C0FFEE;
        oldBase = 26'h2C0FFEE;
        slots(300);
        level1Accept <= 1'b1;
        repeat (4) @(posedge clk);
        level1Accept <= 1'b0;
        n = 0;
        do begin
            next_word(w);
            n++;
        end while (w === IDLE_WORD && n < 10);
        chk(w[29:12] === SOF_CONST, "frame header");
        tdcBase <= 26'h1BADA55;
        first = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (mask[ord[i]]) begin
                for (int j = 0; j < RAM_DEPTH; j++) begin
                    if (first && j == 100) level1Accept <= 1'b1;
                    if (first && j == 101) level1Accept <= 1'b0;
                    next_word(w);
                    chk(w === {oldBase, 4'(ord[i])}, "body word");
                    if (j == 0) chk(frameBusy === 1'b1, "busy in frame");
                end
                first = 1'b0;
            end
        end
        next_word(w);
        chk(w === EOF_WORD, "frame trailer");
        for (int i = 0; i < 5; i++) begin
            next_word(w);
            chk(w === IDLE_WORD && frameBusy === 1'b0, "mid-frame accept dropped");
        end
        $display("test frame_body done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        test_reset_regs();
        test_diag_tdc();
        test_diag_pattern();
        test_frame_ids();
        test_frame_body();
        chk(gapBad === 1'b0, "word cadence");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
